/* File: rtl/mbtp_pkg.sv */
package mbtp_pkg;
    localparam int AD_W = 16;
    localparam int ST_W = 4;
    localparam int NREG = 16;
    localparam int RIDX_W = 4;
    // Status codes on the status lines
    localparam logic [3:0] ST_IO = 4'h2;
    localparam logic [3:0] ST_INTACK = 4'h5;
    localparam logic [3:0] ST_MEM_LO = 4'h8;
    localparam logic [3:0] ST_MEM_HI = 4'hf;
    // Window of I/O addresses answered by this slave
    localparam logic [15:0] IO_BASE = 16'h0040;
    localparam logic [15:0] IO_MASK = 16'hffe0;
    // Memory address space answered
    localparam logic [3:0] MEM_SPACE = 4'h8;
    localparam logic [15:0] MEM_BASE = 16'h8000;
    localparam logic [15:0] MEM_MASK = 16'hffe0;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [7:0] VECTOR_RST = 8'h00;
    localparam logic [2:0] WAIT_CYC = 3'h2;
    typedef enum logic [2:0] {
        MBTP_IDLE = 3'b000,
        MBTP_ADDR = 3'b001,
        MBTP_WAITP = 3'b010,
        MBTP_DATA = 3'b011,
        MBTP_DONE = 3'b100
    } mbtp_state_e;
endpackage

/* File: rtl/mbtp_irq_link.sv */
`timescale 1ns/10ps
// Daisy-chain interrupt node: request, acknowledge, vector
module mbtp_irq_link
(
    input wire logic clk,
    input wire logic rst,
    input wire logic event_pulse,
    input wire logic chain_in,
    input wire logic ack_cycle,
    input wire logic ack_done,
    output logic chain_out_q,
    output logic irq_n_q,
    output logic selected
);
    logic pending_q;
    logic service_q;
    logic chosen_q;

    // Pending is set by events, cleared when acknowledged
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pending_q <= 1'b0;
        end
        else if (event_pulse)
        begin
            pending_q <= 1'b1;
        end
        else if (ack_done && chosen_q)
        begin
            pending_q <= 1'b0;
        end
    end

    // Under-service holds lower devices off from end of acknowledge until pending and ack cycle are both clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            service_q <= 1'b0;
        end
        else if (ack_done && chosen_q)
        begin
            service_q <= 1'b1;
        end
        else if (!pending_q && !ack_cycle)
        begin
            service_q <= 1'b0;
        end
    end

    // Only the highest enabled pending device is chosen
    assign selected = chain_in && pending_q && ack_cycle;

    // Keeps the pick, selection drops once the data strobe rises
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chosen_q <= 1'b0;
        end
        else if (ack_done)
        begin
            chosen_q <= 1'b0;
        end
        else if (selected)
        begin
            chosen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chain_out_q <= 1'b0;
            irq_n_q <= 1'b1;
        end
        else
        begin
            chain_out_q <= chain_in && !pending_q && !service_q;
            irq_n_q <= !(pending_q && chain_in && !service_q);
        end
    end
endmodule

/* File: rtl/mbtp_slave.sv */
`timescale 1ns/10ps
module mbtp_slave
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] ad_in,
    output logic [15:0] ad_out_q,
    output logic ad_oe_q,
    input wire logic addr_phase_strobe_n,
    input wire logic xfer_phase_strobe_n,
    input wire logic [3:0] status,
    input wire logic read_not_write,
    input wire logic byte_not_word,
    output logic wait_n_q,
    input wire logic irq_chain_in,
    output logic irq_chain_out,
    output logic irq_n,
    input wire logic [7:0] vector,
    input wire logic irq_event,
    output logic [15:0] reg0_q,
    output logic wr_pulse_q
);
    logic [15:0] regs_q [mbtp_pkg::NREG];
    logic [15:0] addr_q;
    logic [3:0] status_q;
    logic rnw_q;
    logic bnw_q;
    logic hit_q;
    logic ack_q;
    logic [2:0] wait_cnt_q;
    logic as_prev_q;
    logic ds_prev_q;
    logic as_rise;
    logic ds_fall;
    logic ds_rise;
    logic ack_done;
    logic selected;
    logic chain_out;
    logic irq_low;
    logic [3:0] ridx;
    mbtp_pkg::mbtp_state_e state_q;
    mbtp_pkg::mbtp_state_e state_d;

    // Decides whether a latched address and status belong to this slave
    function automatic logic addr_hit(input logic [3:0] st,
                                      input logic [15:0] a);
        logic r;
        r = 1'b0;
        if (st == mbtp_pkg::ST_IO)
        begin
            r = (a & mbtp_pkg::IO_MASK) == mbtp_pkg::IO_BASE;
        end
        else if (st == mbtp_pkg::MEM_SPACE)
        begin
            r = (a & mbtp_pkg::MEM_MASK) == mbtp_pkg::MEM_BASE;
        end
        return r;
    endfunction

    // Strobe edges, inputs taken as synchronous
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            as_prev_q <= 1'b1;
            ds_prev_q <= 1'b1;
        end
        else
        begin
            as_prev_q <= addr_phase_strobe_n;
            ds_prev_q <= xfer_phase_strobe_n;
        end
    end

    assign as_rise = addr_phase_strobe_n && !as_prev_q;
    assign ds_fall = !xfer_phase_strobe_n && ds_prev_q;
    assign ds_rise = xfer_phase_strobe_n && !ds_prev_q;
    assign ridx = addr_q[4:1];

    // Address phase: follow lines while strobe low, hold at rise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            addr_q <= 16'h0000;
            status_q <= 4'h0;
            hit_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else if (!addr_phase_strobe_n)
        begin
            addr_q <= ad_in;
            status_q <= status;
            hit_q <= addr_hit(status, ad_in);
            ack_q <= status == mbtp_pkg::ST_INTACK;
        end
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            mbtp_pkg::MBTP_IDLE:
            begin
                if (!addr_phase_strobe_n)
                begin
                    state_d = mbtp_pkg::MBTP_ADDR;
                end
            end
            mbtp_pkg::MBTP_ADDR:
            begin
                if (ds_fall && (hit_q || selected))
                begin
                    state_d = mbtp_pkg::MBTP_WAITP;
                end
                else if (!addr_phase_strobe_n && as_rise)
                begin
                    state_d = mbtp_pkg::MBTP_ADDR;
                end
                else if (ds_rise)
                begin
                    state_d = mbtp_pkg::MBTP_IDLE;
                end
            end
            mbtp_pkg::MBTP_WAITP:
            begin
                if (wait_cnt_q == 3'h0)
                begin
                    state_d = mbtp_pkg::MBTP_DATA;
                end
            end
            mbtp_pkg::MBTP_DATA:
            begin
                if (xfer_phase_strobe_n)
                begin
                    state_d = mbtp_pkg::MBTP_DONE;
                end
            end
            mbtp_pkg::MBTP_DONE:
            begin
                state_d = mbtp_pkg::MBTP_IDLE;
            end
            default:
            begin
                state_d = mbtp_pkg::MBTP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= mbtp_pkg::MBTP_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Wait counter stretches the data phase
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_cnt_q <= 3'h0;
            wait_n_q <= 1'b1;
        end
        else if (state_q == mbtp_pkg::MBTP_ADDR && state_d ==
                 mbtp_pkg::MBTP_WAITP)
        begin
            wait_cnt_q <= mbtp_pkg::WAIT_CYC;
            wait_n_q <= 1'b0;
        end
        else if (state_q == mbtp_pkg::MBTP_WAITP && wait_cnt_q != 3'h0)
        begin
            wait_cnt_q <= wait_cnt_q - 3'h1;
        end
        else
        begin
            wait_n_q <= 1'b1;
        end
    end

    // Read data drive, only while data strobe low on a read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ad_out_q <= 16'h0000;
            ad_oe_q <= 1'b0;
        end
        else if (state_d == mbtp_pkg::MBTP_DATA && rnw_q &&
                 !xfer_phase_strobe_n)
        begin
            ad_oe_q <= 1'b1;
            if (ack_q)
            begin
                ad_out_q <= {8'h00, vector};
            end
            else if (bnw_q)
            begin
                // Byte reads copy the lane onto both halves
                ad_out_q <= addr_q[0] ? {2{regs_q[ridx][7:0]}} :
                                        {2{regs_q[ridx][15:8]}};
            end
            else
            begin
                ad_out_q <= regs_q[ridx];
            end
        end
        else
        begin
            ad_oe_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rnw_q <= 1'b1;
            bnw_q <= 1'b0;
        end
        else if (ds_fall)
        begin
            rnw_q <= read_not_write;
            bnw_q <= byte_not_word;
        end
    end

    // Write commits at end of data phase, direct register select
    generate
        for (genvar i = 0; i < mbtp_pkg::NREG; i++)
        begin : g_reg
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    regs_q[i] <= mbtp_pkg::REG_RST;
                end
                else if (state_q == mbtp_pkg::MBTP_DATA &&
                         xfer_phase_strobe_n && !rnw_q && !ack_q &&
                         ridx == 4'(i))
                begin
                    if (!bnw_q)
                    begin
                        regs_q[i] <= ad_in;
                    end
                    else if (addr_q[0])
                    begin
                        regs_q[i][7:0] <= ad_in[7:0];
                    end
                    else
                    begin
                        regs_q[i][15:8] <= ad_in[15:8];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg0_q <= mbtp_pkg::REG_RST;
            wr_pulse_q <= 1'b0;
        end
        else
        begin
            reg0_q <= regs_q[0];
            wr_pulse_q <= state_q == mbtp_pkg::MBTP_DATA &&
                          xfer_phase_strobe_n && !rnw_q && !ack_q;
        end
    end

    assign ack_done = state_q == mbtp_pkg::MBTP_DONE && ack_q;

    mbtp_irq_link u_irq
    (
        .clk(clk),
        .rst(rst),
        .event_pulse(irq_event),
        .chain_in(irq_chain_in),
        .ack_cycle(ack_q && !xfer_phase_strobe_n),
        .ack_done(ack_done),
        .chain_out_q(chain_out),
        .irq_n_q(irq_low),
        .selected(selected)
    );

    assign irq_chain_out = chain_out;
    assign irq_n = irq_low;
endmodule

/* File: sim/mbtp_monitor.sv */
`timescale 1ns/10ps
module mbtp_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] ad_in,
    input wire logic [15:0] ad_out_q,
    input wire logic ad_oe_q,
    input wire logic addr_phase_strobe_n,
    input wire logic xfer_phase_strobe_n,
    input wire logic [3:0] status,
    input wire logic read_not_write,
    input wire logic byte_not_word,
    input wire logic wait_n_q,
    input wire logic irq_chain_in,
    input wire logic irq_n,
    input wire logic irq_event,
    input wire logic wr_pulse_q
);
    logic [15:0] addr_q;
    logic hit;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            addr_q <= 16'h0;
        else if (!addr_phase_strobe_n)
            addr_q <= ad_in;
    end
    // Transfer aimed at this slave
    assign hit = (status == mbtp_pkg::ST_IO
        && (addr_q & mbtp_pkg::IO_MASK) == mbtp_pkg::IO_BASE)
        || (status == mbtp_pkg::MEM_SPACE
        && (addr_q & mbtp_pkg::MEM_MASK) == mbtp_pkg::MEM_BASE);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_ds_fall;
        $fell(xfer_phase_strobe_n);
    endsequence
    sequence s_wait_hold;
        !wait_n_q [*2] ##[1:3] wait_n_q;
    endsequence
    property p_idle;
        $fell(rst) |-> wait_n_q && !ad_oe_q && irq_n;
    endproperty
    a_idle: assert property (p_idle) else $error("bad idle");
    property p_wait_on;
        s_ds_fall ##0 hit |-> ##[1:2] !wait_n_q;
    endproperty
    a_wait_on: assert property (p_wait_on) else $error("no wait");
    property p_wait_len;
        $fell(wait_n_q) |-> s_wait_hold;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("wait len");
    property p_refuse;
        s_ds_fall ##0 (!hit && status != mbtp_pkg::ST_INTACK)
            |-> (wait_n_q && !ad_oe_q) [*6];
    endproperty
    a_refuse: assert property (p_refuse) else $error("answered miss");
    property p_read_drive;
        $rose(wait_n_q) && read_not_write |-> ##[0:1] ad_oe_q;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("no drive");
    property p_write_quiet;
        !xfer_phase_strobe_n && !read_not_write |-> !ad_oe_q;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("drove");
    property p_byte_lane;
        ad_oe_q && byte_not_word && status != mbtp_pkg::ST_INTACK
            |-> ad_out_q[15:8] == ad_out_q[7:0];
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("lane");
    property p_wr_pulse;
        $rose(xfer_phase_strobe_n) ##0 (hit && !read_not_write)
            |-> ##[1:2] wr_pulse_q ##1 !wr_pulse_q;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("wr pulse");
    property p_irq;
        irq_event && irq_chain_in |-> ##[1:3] !irq_n;
    endproperty
    a_irq: assert property (p_irq) else $error("no irq");
endmodule
bind mbtp_slave mbtp_monitor u_mon (.clk(clk), .rst(rst), .ad_in(ad_in),
    .ad_out_q(ad_out_q), .ad_oe_q(ad_oe_q),
    .addr_phase_strobe_n(addr_phase_strobe_n),
    .xfer_phase_strobe_n(xfer_phase_strobe_n), .status(status),
    .read_not_write(read_not_write), .byte_not_word(byte_not_word),
    .wait_n_q(wait_n_q), .irq_chain_in(irq_chain_in), .irq_n(irq_n),
    .irq_event(irq_event), .wr_pulse_q(wr_pulse_q));

/* File: sim/mbtp_master_model.sv */
`timescale 1ns/10ps
// Bus master: strobes, qualifiers and the shared line level
module mbtp_master_model
(
    input wire logic clk,
    input wire logic [15:0] ad_out_q,
    input wire logic ad_oe_q,
    input wire logic wait_n_q,
    output logic [15:0] ad_in,
    output logic addr_phase_strobe_n,
    output logic xfer_phase_strobe_n,
    output logic [3:0] status,
    output logic read_not_write,
    output logic byte_not_word
);
    logic [15:0] drv = 16'h0;
    logic [15:0] last_q = 16'h0;
    logic en = 1'b0;
    // Released lines float: show the inverse of the last level
    assign ad_in = ad_oe_q ? ad_out_q : en ? drv : ~last_q;
    always @(posedge clk)
        last_q <= ad_in;
    initial
    begin
        addr_phase_strobe_n = 1'b1;
        xfer_phase_strobe_n = 1'b1;
        status = 4'h0;
        read_not_write = 1'b1;
        byte_not_word = 1'b0;
    end
    task automatic xfer(input logic [3:0] st, input logic [15:0] a,
        input logic rd, input logic bt, input logic [15:0] wd,
        output logic [15:0] q, output logic w, output logic to);
        int n;
        @(negedge clk);
        status = st;
        read_not_write = rd;
        byte_not_word = bt;
        drv = a;
        en = 1'b1;
        addr_phase_strobe_n = 1'b0;
        @(negedge clk);
        addr_phase_strobe_n = 1'b1;
        drv = wd;
        en = !rd;
        @(negedge clk);
        xfer_phase_strobe_n = 1'b0;
        w = 1'b0;
        to = 1'b1;
        // Stretched while wait is low; timing from strobes only
        for (n = 0; n < 16; n++)
        begin
            // Sample settled outputs away from the launching edge
            @(negedge clk);
            q = ad_in;
            if (!wait_n_q)
                w = 1'b1;
            else if (w || n > 4)
            begin
                to = 1'b0;
                break;
            end
        end
        xfer_phase_strobe_n = 1'b1;
        @(negedge clk);
        en = 1'b0;
        @(negedge clk);
    endtask
endmodule

/* File: sim/muxed_bus_transfer_port_test.sv */
`timescale 1ns/10ps
module muxed_bus_transfer_port_test;
    localparam logic [3:0] IO = mbtp_pkg::ST_IO;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic irq_chain_in = 1'b1;
    logic irq_event = 1'b0;
    logic [7:0] vector = 8'h0;
    logic [15:0] ad_in, ad_out_q, reg0_q, q;
    logic [3:0] status;
    logic ad_oe_q, addr_phase_strobe_n, xfer_phase_strobe_n, w;
    logic read_not_write, byte_not_word, wait_n_q, irq_chain_out;
    logic irq_n, wr_pulse_q;
    int failures = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    mbtp_slave dut (.clk(clk), .rst(rst), .ad_in(ad_in),
        .ad_out_q(ad_out_q), .ad_oe_q(ad_oe_q),
        .addr_phase_strobe_n(addr_phase_strobe_n),
        .xfer_phase_strobe_n(xfer_phase_strobe_n), .status(status),
        .read_not_write(read_not_write), .byte_not_word(byte_not_word),
        .wait_n_q(wait_n_q), .irq_chain_in(irq_chain_in),
        .irq_chain_out(irq_chain_out), .irq_n(irq_n), .vector(vector),
        .irq_event(irq_event), .reg0_q(reg0_q), .wr_pulse_q(wr_pulse_q));
    mbtp_master_model m (.clk(clk), .ad_out_q(ad_out_q),
        .ad_oe_q(ad_oe_q), .wait_n_q(wait_n_q), .ad_in(ad_in),
        .addr_phase_strobe_n(addr_phase_strobe_n),
        .xfer_phase_strobe_n(xfer_phase_strobe_n), .status(status),
        .read_not_write(read_not_write), .byte_not_word(byte_not_word));
    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic [3:0] st, input logic [15:0] a,
        input logic rd, input logic bt, input logic [15:0] wd);
        logic to;
        m.xfer(st, a, rd, bt, wd, q, w, to);
        if (to)
        begin
            failures++;
            test_done();
        end
    endtask
    task automatic t_reset;
        chk("wait_n", 16'(wait_n_q), 16'h1);
        chk("oe", 16'(ad_oe_q), 16'h0);
        chk("reg0", reg0_q, mbtp_pkg::REG_RST);
        $display("reset test done");
    endtask
    task automatic t_io;
        bus(IO, 16'h0040, 1'h0, 1'h0, 16'h1234);
        chk("wait seen", 16'(w), 16'h1);
        bus(IO, 16'h005e, 1'h0, 1'h0, 16'hbeef);
        bus(IO, 16'h0040, 1'h1, 1'h0, 16'h0);
        chk("io reg0", q, 16'h1234);
        chk("reg0 copy", reg0_q, 16'h1234);
        bus(IO, 16'h005e, 1'h1, 1'h0, 16'h0);
        chk("io reg15", q, 16'hbeef);
        bus(mbtp_pkg::MEM_SPACE, 16'h801c, 1'h0, 1'h0, 16'hc3a5);
        bus(mbtp_pkg::MEM_SPACE, 16'h801c, 1'h1, 1'h0, 16'h0);
        chk("mem word", q, 16'hc3a5);
        $display("word test done");
    endtask
    task automatic t_byte;
        bus(IO, 16'h0041, 1'h0, 1'h1, 16'ha5a5);
        bus(IO, 16'h0040, 1'h0, 1'h1, 16'h7e7e);
        bus(IO, 16'h0040, 1'h1, 1'h0, 16'h0);
        chk("word after bytes", q, 16'h7ea5);
        bus(IO, 16'h0041, 1'h1, 1'h1, 16'h0);
        chk("low byte read", q, 16'ha5a5);
        bus(IO, 16'h0040, 1'h1, 1'h1, 16'h0);
        chk("high byte read", q, 16'h7e7e);
        $display("byte test done");
    endtask
    task automatic miss(input logic [3:0] st, input logic [15:0] a);
        bus(st, a, 1'h1, 1'h0, 16'h0);
        chk("miss wait", 16'(w), 16'h0);
    endtask
    task automatic t_miss;
        miss(IO, 16'h0060);
        miss(IO, 16'h003e);
        miss(mbtp_pkg::MEM_SPACE, 16'h8020);
        miss(IO, 16'h8000);
        bus(IO, 16'h0060, 1'h0, 1'h0, 16'hdead);
        chk("reg0 kept", reg0_q, 16'h7ea5);
        $display("refuse test done");
    endtask
    task automatic t_irq;
        chk("chain pass", 16'(irq_chain_out), 16'h1);
        irq_chain_in = 1'b0;
        repeat (2) @(negedge clk);
        chk("chain block", 16'(irq_chain_out), 16'h0);
        irq_chain_in = 1'b1;
        vector = 8'h3c;
        irq_event = 1'b1;
        @(negedge clk);
        irq_event = 1'b0;
        repeat (3) @(negedge clk);
        chk("irq low", 16'(irq_n), 16'h0);
        bus(mbtp_pkg::ST_INTACK, 16'h0, 1'h1, 1'h0, 16'h0);
        chk("vector", 16'(q[7:0]), 16'h3c);
        repeat (2) @(negedge clk);
        chk("irq clear", 16'(irq_n), 16'h1);
        $display("interrupt test done");
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_io();
        t_byte();
        t_miss();
        t_irq();
        test_done();
    end
endmodule
